// File: verilog/pso_output_control.sv
// bus target with packet check, alert response, settings store and output control
// assumes async bus pins and straps; fault and telemetry inputs on sys_clk
//
// Operation
// - works at 100 kHz and 400 kHz bus clock rates.
// - never holds the bus clock low.
// - check byte used only if host clocks it before stop.
// - non-voltage data words use linear format with fixed per-command exponent.
// - direct data format is not supported.
// - answers alert response address only when alerting, returns own address.
// - bus writes change working registers only, not the store.
// - store-default-all copies storable working settings into the store.
// - telemetry readback is linear; output voltage commands use VID encoding.
// - output mode byte read-only and output voltage word in VID.
// - linear word: 11-bit signed mantissa, 5-bit signed exponent, Y times 2^N.
// - linear inputs accepted for any exponent.
// - bus address is one of sixteen, from the address strap pin.
// - strap mode loads strap settings at power-up; later writes override.
// - bit 7 is on/off request, reset 0, effective only with command-honour.
// - on needs input above undervoltage threshold and pin honour clear or pin asserted.
// - bit 6 soft-off is read-only, always reads 0.
// - margin low or high regulates to stored margin voltage.
// - margin field codes: 00xx off, 0101/0110 low, 1001/1010 high.
// - bits 1-0 equal 01 raise hot flag on input overcurrent warning.
// - command-honour is on/off configuration bit 3, reset 0.
// - pin-honour is on/off configuration bit 2, reset 1.
`timescale 1ns/1ps
`include "pso_defs.svh"
module pso_output_control (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic alert_event,
   output logic alert_out,
   output logic alert_oe,
   input wire logic [3:0] address_risetime_strap_pin,
   input wire logic strap_mode,
   input wire logic [7:0] strap_boot_vid,
   input wire logic enable_pin,
   input wire logic input_overcurrent_warning_limit,
   input wire logic [15:0] vin_sense_fix,
   output logic output_enable,
   output logic [15:0] vout_target,
   output logic margin_fault_act,
   output logic regulator_hot_flag,
   output logic init_done
);
   import pso_pkg::*;

   // ****************************************
   // functions
   // ****************************************
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? `PSO_CRC_POLY : 8'h00);
      end
      return r;
   endfunction

   // linear word to signed fixed point, any exponent
   function automatic logic signed [39:0] lin_to_fix(input logic [15:0] w);
      logic signed [39:0] y;
      y = {{29{w[10]}}, w[10:0]};
      y = y <<< `PSO_FIX_FRAC;
      if (w[15]) begin
         return y >>> (6'd32 - {1'b0, w[15:11]});
      end
      return y <<< w[15:11];
   endfunction

   // fixed point to linear, own exponent
   function automatic logic [15:0] fix_to_lin(input logic signed [39:0] f);
      logic signed [39:0] t;
      t = f >>> `PSO_LIN_SHIFT;
      return {`PSO_LIN_EXP, t[10:0]};
   endfunction

   function automatic logic [1:0] cmd_len(input logic [7:0] c);
      case (c)
         `PSO_CMD_STORE: cmd_len = 2'd0;
         `PSO_CMD_OPER, `PSO_CMD_ONOFF, `PSO_CMD_VMODE: cmd_len = 2'd1;
         default: cmd_len = 2'd2;
      endcase
   endfunction

   function automatic logic [15:0] reg_read(input pso_regs_type r, input logic [7:0] c, input logic [15:0] vin);
      case (c)
         `PSO_CMD_OPER: reg_read = {8'h00, r.operation};
         `PSO_CMD_ONOFF: reg_read = {8'h00, `PSO_ONOFF_FIXED | {4'h0, r.onoff_cmd, r.onoff_cp, 2'h0}};
         `PSO_CMD_VMODE: reg_read = {8'h00, `PSO_VMODE_VAL};
         `PSO_CMD_VCMD: reg_read = r.vout_cmd;
         `PSO_CMD_MHI: reg_read = r.margin_hi;
         `PSO_CMD_MLO: reg_read = r.margin_lo;
         `PSO_CMD_UVLO: reg_read = r.uvlo;
         `PSO_CMD_VIN: reg_read = vin;
         default: reg_read = 16'h0000;
      endcase
   endfunction

   function automatic logic [7:0] nvm_cmd(input logic [2:0] i);
      case (i)
         3'h0: nvm_cmd = `PSO_CMD_ONOFF;
         3'h1: nvm_cmd = `PSO_CMD_VCMD;
         3'h2: nvm_cmd = `PSO_CMD_MHI;
         3'h3: nvm_cmd = `PSO_CMD_MLO;
         default: nvm_cmd = `PSO_CMD_UVLO;
      endcase
   endfunction

   // ****************************************
   // pin synchronisers and bus edge detect
   // ****************************************
   logic [15:0] pin_meta_reg, pin_sync_reg;
   logic scl_d_reg, sda_d_reg;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pin_meta_reg <= `PSO_PIN_IDLE;
         pin_sync_reg <= `PSO_PIN_IDLE;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         pin_meta_reg <= {strap_boot_vid, address_risetime_strap_pin, strap_mode, enable_pin, scl_in, sda_in};
         pin_sync_reg <= pin_meta_reg;
         scl_d_reg <= pin_sync_reg[1];
         sda_d_reg <= pin_sync_reg[0];
      end
   end
   wire sda = pin_sync_reg[0];
   wire scl = pin_sync_reg[1];
   wire en_pin = pin_sync_reg[2];
   wire s_mode = pin_sync_reg[3];
   wire [3:0] s_addr = pin_sync_reg[7:4];
   wire [7:0] s_vid = pin_sync_reg[15:8];
   // 100x oversampling at 400 kHz keeps edges inside each phase
   wire scl_rise = scl & ~scl_d_reg;
   wire scl_fall = ~scl & scl_d_reg;
   wire bus_start = scl & scl_d_reg & sda_d_reg & ~sda;
   wire bus_stop = scl & scl_d_reg & ~sda_d_reg & sda;

   // ****************************************
   // working registers and settings store
   // ****************************************
   pso_regs_type regs_reg;
   pso_seq_state_type seq_reg;
   pso_nvm_req_type nvm_req;
   logic [2:0] seq_idx_reg, load_idx_reg;
   logic load_valid_reg, init_done_reg;
   logic [6:0] own_addr_reg;
   logic [15:0] nvm_rd;
   logic commit_wr;
   logic [7:0] cmd_reg;
   logic [2:0][7:0] rx_buf_reg;

   pso_nvm u_nvm (
      .sys_clk(sys_clk),
      .req(nvm_req),
      .rd_data(nvm_rd)
   );

   wire [15:0] vin_lin = fix_to_lin($signed({24'h00_0000, vin_sense_fix}));
   wire [7:0] load_cmd = nvm_cmd(load_idx_reg);
   wire [15:0] load_word = (load_cmd == `PSO_CMD_VCMD && s_mode) ? {8'h00, s_vid} : nvm_rd;
   wire reg_we = load_valid_reg | commit_wr;
   wire [7:0] reg_sel = load_valid_reg ? load_cmd : cmd_reg;
   wire [15:0] reg_word = load_valid_reg ? load_word : {rx_buf_reg[1], rx_buf_reg[0]};
   wire store_go = commit_wr && cmd_reg == `PSO_CMD_STORE;
   assign nvm_req.wr = (seq_reg == SEQ_STORE);
   assign nvm_req.addr = seq_idx_reg;
   assign nvm_req.data = reg_read(regs_reg, nvm_cmd(seq_idx_reg), vin_lin);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         seq_reg <= SEQ_LOAD;
         seq_idx_reg <= 3'h0;
         load_idx_reg <= 3'h0;
         load_valid_reg <= 1'b0;
         init_done_reg <= 1'b0;
      end else begin
         load_valid_reg <= (seq_reg == SEQ_LOAD);
         load_idx_reg <= seq_idx_reg;
         init_done_reg <= init_done_reg | (seq_reg != SEQ_LOAD);
         case (seq_reg)
            SEQ_LOAD, SEQ_STORE: begin
               seq_idx_reg <= seq_idx_reg + 3'h1;
               if (seq_idx_reg == `PSO_NVM_LAST) begin
                  seq_reg <= SEQ_IDLE;
                  seq_idx_reg <= 3'h0;
               end
            end
            SEQ_IDLE: begin
               if (store_go) begin
                  seq_reg <= SEQ_STORE;
               end
            end
            default: seq_reg <= SEQ_IDLE;
         endcase
      end
   end

   // strap caught during the power-up load
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         own_addr_reg <= 7'h00;
      end else if (seq_reg == SEQ_LOAD) begin
         own_addr_reg <= {`PSO_ADDR_HI, s_addr};
      end
   end

   // bus writes: working registers only
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         regs_reg.operation <= `PSO_OPER_RST;
         regs_reg.onoff_cmd <= `PSO_ONOFF_CMD_RST;
         regs_reg.onoff_cp <= `PSO_ONOFF_CP_RST;
         regs_reg.vout_cmd <= `PSO_NVM_VCMD;
         regs_reg.margin_hi <= `PSO_NVM_MHI;
         regs_reg.margin_lo <= `PSO_NVM_MLO;
         regs_reg.uvlo <= `PSO_NVM_UVLO;
      end else if (reg_we) begin
         case (reg_sel)
            `PSO_CMD_OPER: regs_reg.operation <= reg_word[7:0] & `PSO_OPER_WMASK;
            `PSO_CMD_ONOFF: begin
               regs_reg.onoff_cmd <= reg_word[`PSO_ONOFF_CMD];
               regs_reg.onoff_cp <= reg_word[`PSO_ONOFF_CP];
            end
            `PSO_CMD_VCMD: regs_reg.vout_cmd <= reg_word;
            `PSO_CMD_MHI: regs_reg.margin_hi <= reg_word;
            `PSO_CMD_MLO: regs_reg.margin_lo <= reg_word;
            `PSO_CMD_UVLO: regs_reg.uvlo <= fix_to_lin(lin_to_fix(reg_word));
            default: regs_reg.uvlo <= regs_reg.uvlo;
         endcase
      end
   end

   // ****************************************
   // bus target
   // ****************************************
   pso_bus_state_type state_reg;
   logic [7:0] shift_reg, crc_reg, crc_prev_reg;
   logic [3:0] bit_cnt_reg;
   logic [1:0] rx_cnt_reg, rd_idx_reg;
   logic rw_reg, ara_reg, addr_done_reg, cmd_valid_reg, in_frame_reg, sda_drive_reg, alert_reg;

   wire addr_hit = init_done_reg && shift_reg[7:1] == own_addr_reg;
   wire ara_hit = alert_reg && shift_reg == {`PSO_ARA, 1'b1};
   wire [1:0] len = cmd_len(cmd_reg);
   wire [15:0] rd_word = reg_read(regs_reg, cmd_reg, vin_lin);
   wire [7:0] rd_data_byte = rd_idx_reg[0] ? rd_word[15:8] : rd_word[7:0];
   wire [7:0] ara_byte = (rd_idx_reg == 2'd0) ? {own_addr_reg, 1'b0} : crc_reg;
   wire [7:0] norm_byte = (rd_idx_reg < len) ? rd_data_byte : (rd_idx_reg == len) ? crc_reg : 8'hFF;
   wire [7:0] tx_byte = ara_reg ? ara_byte : norm_byte;
   wire load_tx = scl_fall && ((state_reg == BUS_ACK && rw_reg) || state_reg == BUS_TXACK);
   wire ara_clear = load_tx && ara_reg && rd_idx_reg == 2'd0;
   // check byte counts only if clocked before stop
   wire pec_ok = (rx_cnt_reg == len + 2'd1) && crc_prev_reg == rx_buf_reg[len];
   wire len_ok = (rx_cnt_reg == len) || pec_ok;
   assign commit_wr = bus_stop && in_frame_reg && cmd_valid_reg && !rw_reg && !ara_reg && len_ok
      && seq_reg == SEQ_IDLE;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= BUS_IDLE;
         {shift_reg, crc_reg, crc_prev_reg, cmd_reg} <= 32'h0000_0000;
         rx_buf_reg <= 24'h00_0000;
         {bit_cnt_reg, rx_cnt_reg, rd_idx_reg} <= 8'h00;
         {rw_reg, ara_reg, addr_done_reg, cmd_valid_reg, in_frame_reg, sda_drive_reg} <= 6'h00;
      end else if (bus_stop) begin
         state_reg <= BUS_IDLE;
         in_frame_reg <= 1'b0;
         sda_drive_reg <= 1'b0;
      end else if (bus_start) begin
         state_reg <= BUS_RX;
         bit_cnt_reg <= 4'h0;
         addr_done_reg <= 1'b0;
         in_frame_reg <= 1'b1;
         sda_drive_reg <= 1'b0;
         if (!in_frame_reg) begin
            crc_reg <= 8'h00;
            cmd_valid_reg <= 1'b0;
            rx_cnt_reg <= 2'd0;
         end
      end else if (load_tx) begin
         state_reg <= BUS_TX;
         shift_reg <= tx_byte;
         sda_drive_reg <= ~tx_byte[7];
         bit_cnt_reg <= 4'h1;
         crc_reg <= crc8(crc_reg, tx_byte);
         if (rd_idx_reg != 2'd3) begin
            rd_idx_reg <= rd_idx_reg + 2'd1;
         end
      end else begin
         case (state_reg)
            BUS_RX: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                  crc_prev_reg <= crc_reg;
                  crc_reg <= crc8(crc_reg, shift_reg);
                  state_reg <= BUS_ACK;
                  sda_drive_reg <= 1'b1;
                  if (!addr_done_reg) begin
                     addr_done_reg <= 1'b1;
                     rw_reg <= shift_reg[0];
                     ara_reg <= ara_hit;
                     rd_idx_reg <= 2'd0;
                     if (!(addr_hit || ara_hit)) begin
                        state_reg <= BUS_IDLE;
                        sda_drive_reg <= 1'b0;
                     end
                  end else if (!cmd_valid_reg) begin
                     cmd_reg <= shift_reg;
                     cmd_valid_reg <= 1'b1;
                  end else if (rx_cnt_reg != 2'd3) begin
                     rx_buf_reg[rx_cnt_reg] <= shift_reg;
                     rx_cnt_reg <= rx_cnt_reg + 2'd1;
                  end
               end
            end
            BUS_ACK: begin
               if (scl_fall) begin
                  state_reg <= BUS_RX;
                  bit_cnt_reg <= 4'h0;
                  sda_drive_reg <= 1'b0;
               end
            end
            BUS_TX: begin
               if (scl_fall) begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  sda_drive_reg <= (bit_cnt_reg == 4'h8) ? 1'b0 : ~shift_reg[6];
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == 4'h8) begin
                     state_reg <= BUS_TXACK;
                  end
               end
            end
            BUS_TXACK: begin
               if (scl_rise && sda) begin
                  state_reg <= BUS_IDLE;
               end
            end
            default: state_reg <= BUS_IDLE;
         endcase
      end
   end

   // alert: a new event beats the response clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= alert_event | (alert_reg & ~ara_clear);
      end
   end

   // ****************************************
   // output control
   // ****************************************
   logic output_enable_reg, margin_act_reg, hot_reg;
   logic [15:0] vout_target_reg;
   wire [3:0] msel = regs_reg.operation[`PSO_MARGIN_HI:`PSO_MARGIN_LO];
   wire [1:0] hot_sel = regs_reg.operation[`PSO_HOT_HI:`PSO_HOT_LO];
   wire m_low = msel == `PSO_MARGIN_LOW_IGN || msel == `PSO_MARGIN_LOW_ACT;
   wire m_high = msel == `PSO_MARGIN_HIGH_IGN || msel == `PSO_MARGIN_HIGH_ACT;
   wire vin_ok = $signed({24'h00_0000, vin_sense_fix}) > lin_to_fix(regs_reg.uvlo);
   wire pin_ok = !regs_reg.onoff_cp || en_pin;
   wire on_req = regs_reg.operation[`PSO_OPER_ON] && regs_reg.onoff_cmd;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         output_enable_reg <= 1'b0;
         margin_act_reg <= 1'b0;
         hot_reg <= 1'b0;
         vout_target_reg <= 16'h0000;
      end else begin
         output_enable_reg <= on_req && vin_ok && pin_ok;
         vout_target_reg <= m_low ? regs_reg.margin_lo : m_high ? regs_reg.margin_hi : regs_reg.vout_cmd;
         margin_act_reg <= msel == `PSO_MARGIN_LOW_ACT || msel == `PSO_MARGIN_HIGH_ACT;
         hot_reg <= hot_sel == `PSO_HOT_ON && input_overcurrent_warning_limit;
      end
   end

   // open drain: only ever pull data low; clock is never driven
   assign sda_out = 1'b0;
   assign sda_oe = sda_drive_reg;
   assign alert_out = 1'b0;
   assign alert_oe = alert_reg;
   assign output_enable = output_enable_reg;
   assign vout_target = vout_target_reg;
   assign margin_fault_act = margin_act_reg;
   assign regulator_hot_flag = hot_reg;
   assign init_done = init_done_reg;
endmodule // pso_output_control

// File: common/pso_defs.svh
// constants for the bus target and output control block
// assumes one 40 MHz clock and 7-bit bus addressing
`ifndef PSO_DEFS_SVH
`define PSO_DEFS_SVH
// command codes
`define PSO_CMD_OPER 8'h01
`define PSO_CMD_ONOFF 8'h02
`define PSO_CMD_STORE 8'h11
`define PSO_CMD_VMODE 8'h20
`define PSO_CMD_VCMD 8'h21
`define PSO_CMD_MHI 8'h25
`define PSO_CMD_MLO 8'h26
`define PSO_CMD_UVLO 8'h35
`define PSO_CMD_VIN 8'h88
// output control register
`define PSO_OPER_RST 8'h00
`define PSO_OPER_WMASK 8'hBF
`define PSO_OPER_ON 7
`define PSO_MARGIN_HI 5
`define PSO_MARGIN_LO 2
`define PSO_HOT_HI 1
`define PSO_HOT_LO 0
`define PSO_HOT_ON 2'h1
`define PSO_MARGIN_LOW_IGN 4'h5
`define PSO_MARGIN_LOW_ACT 4'h6
`define PSO_MARGIN_HIGH_IGN 4'h9
`define PSO_MARGIN_HIGH_ACT 4'hA
// on/off configuration
`define PSO_ONOFF_CMD 3
`define PSO_ONOFF_CP 2
`define PSO_ONOFF_CMD_RST 1'b0
`define PSO_ONOFF_CP_RST 1'b1
`define PSO_ONOFF_FIXED 8'h13
// data formats
`define PSO_VMODE_VAL 8'h20
`define PSO_FIX_FRAC 8
`define PSO_LIN_SHIFT 6
`define PSO_LIN_EXP 5'h1E
// bus
`define PSO_ARA 7'h0C
`define PSO_ADDR_HI 3'h4
`define PSO_CRC_POLY 8'h07
`define PSO_PIN_IDLE 16'h0003
// non-volatile store: slots 0..4 = on/off, vout, margin high, margin low, uvlo
`define PSO_NVM_LAST 3'h4
`define PSO_NVM_ONOFF 16'h0017
`define PSO_NVM_VCMD 16'h0000
`define PSO_NVM_MHI 16'h0000
`define PSO_NVM_MLO 16'h0000
`define PSO_NVM_UVLO 16'hF010
`endif

// File: common/pso_pkg.sv
// types shared by the bus target and its settings store
// assumes pso_defs.svh for all numeric constants
package pso_pkg;
   typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_ACK, BUS_TX, BUS_TXACK} pso_bus_state_type;
   typedef enum logic [1:0] {SEQ_LOAD, SEQ_IDLE, SEQ_STORE} pso_seq_state_type;
   typedef struct packed {
      logic wr;
      logic [2:0] addr;
      logic [15:0] data;
   } pso_nvm_req_type;
   typedef struct packed {
      logic [7:0] operation;
      logic onoff_cmd;
      logic onoff_cp;
      logic [15:0] vout_cmd;
      logic [15:0] margin_hi;
      logic [15:0] margin_lo;
      logic [15:0] uvlo;
   } pso_regs_type;
endpackage

// File: verilog/pso_nvm.sv
// settings store holding power-up defaults, registered read port
// assumes contents survive the block reset, as non-volatile cells do
`timescale 1ns/1ps
`include "pso_defs.svh"
module pso_nvm (
   input wire logic sys_clk,
   input pso_pkg::pso_nvm_req_type req,
   output logic [15:0] rd_data
);
   import pso_pkg::*;
   logic [15:0] mem [0:7];

   initial begin
      for (int i = 0; i < 8; i++) begin
         mem[i] = 16'h0000;
      end
      mem[0] = `PSO_NVM_ONOFF;
      mem[1] = `PSO_NVM_VCMD;
      mem[2] = `PSO_NVM_MHI;
      mem[3] = `PSO_NVM_MLO;
      mem[4] = `PSO_NVM_UVLO;
   end

   always_ff @(posedge sys_clk) begin
      if (req.wr) begin
         mem[req.addr] <= req.data;
      end
      rd_data <= mem[req.addr];
   end
endmodule // pso_nvm

// File: bench/pso_checker.sv
// assertions on the ports of the output control block
// assumes the bind below, one sys_clk domain
`timescale 1ns/1ps
module pso_checker (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic alert_event,
   input wire logic alert_out,
   input wire logic alert_oe,
   input wire logic input_overcurrent_warning_limit,
   input wire logic output_enable,
   input wire logic margin_fault_act,
   input wire logic regulator_hot_flag,
   input wire logic init_done
);
   // ***
   // port relations
   // ***
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_open_drain_low: assert property (sda_out == 1'b0 && alert_out == 1'b0)
      else $error("open drain value high");
   a_reset_quiet: assert property (disable iff (1'b0) reset |=> !sda_oe && !alert_oe && !output_enable)
      else $error("outputs active after reset");
   a_init_bound: assert property ($fell(reset) |-> ##[0:8] init_done)
      else $error("power-up load too slow");
   a_data_on_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
      else $error("data changed outside clock low");
   a_alert_raise: assert property (alert_event |=> alert_oe)
      else $error("alert not raised");
   a_alert_cause: assert property ($rose(alert_oe) |-> $past(alert_event))
      else $error("alert without cause");
   a_silent_init: assert property (!init_done |-> !sda_oe)
      else $error("bus answered before load");
   a_hot_cause: assert property (!input_overcurrent_warning_limit |=> !regulator_hot_flag)
      else $error("hot flag without warning");
   c_output_on: cover property ($rose(output_enable));
   c_alert_clear: cover property ($fell(alert_oe));
   c_margin_act: cover property ($rose(margin_fault_act));
endmodule // pso_checker
bind pso_output_control pso_checker u_pso_checker (.sys_clk, .reset, .scl_in, .sda_out, .sda_oe, .alert_event,
   .alert_out, .alert_oe, .input_overcurrent_warning_limit, .output_enable, .margin_fault_act,
   .regulator_hot_flag, .init_done);

// File: bench/pso_host_model.sv
// bus host model with check byte and alert response read
// assumes the bench wires data as open drain with a pull-up
`timescale 1ns/1ps
`include "pso_defs.svh"
module pso_host_model (
   input wire logic sys_clk,
   input wire logic sda_in,
   output logic scl_in,
   output logic sda_host
);
   logic [7:0] crc;
   logic ack, r;
   initial begin
      scl_in = 1'b1;
      sda_host = 1'b1;
   end
   // ***
   // bit and byte level, clock stands high between frames
   // ***
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      repeat (8) x = x[7] ? ((x << 1) ^ `PSO_CRC_POLY) : (x << 1);
      return x;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic drv(input logic d, input logic c);
      tick(2);
      sda_host = d;
      tick(2);
      scl_in = c;
   endtask
   task automatic bit_io(input logic b, output logic q);
      drv(b, 1'b1);
      tick(2);
      q = sda_in;
      tick(2);
      scl_in = 1'b0;
   endtask
   task automatic start();
      drv(1'b1, 1'b1);
      drv(1'b0, 1'b0);
   endtask
   task automatic put(input logic [7:0] d);
      for (int j = 7; j >= 0; j--) bit_io(d[j], r);
      bit_io(1'b1, ack);
      crc = crc8(crc, d);
   endtask
   task automatic get(input logic last, output logic [7:0] q);
      for (int j = 7; j >= 0; j--) bit_io(1'b1, q[j]);
      bit_io(last, r);
      crc = crc8(crc, q);
   endtask
   // nw < 0: receive byte only
   task automatic xact(input logic [6:0] a, input logic [7:0] cmd, input int nw, input logic [15:0] wd,
      input int nr, input int pec, output logic [15:0] rd, output logic nak);
      logic [7:0] b;
      crc = 8'h00;
      nak = 1'b0;
      rd = 16'hFFFF;
      start();
      if (nw >= 0) begin
         put({a, 1'b0});
         nak = ack;
         if (!nak) put(cmd);
         for (int i = 0; i < nw && !nak; i++) put(wd[8*i +: 8]);
         if (!nak && nr > 0) start();
      end
      if (!nak && nr > 0) begin
         put({a, 1'b1});
         nak = ack;
         for (int i = 0; i < nr && !nak; i++) begin
            get(i == nr - 1, b);
            rd[8*i +: 8] = b;
         end
      end
      if (!nak && nr == 0 && pec != 0) put(pec == 1 ? crc : ~crc);
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
      tick(6);
   endtask
endmodule // pso_host_model

// File: bench/tb_pso_output_control.sv
// self-checking bench for the output control block
// assumes the host model on the bus pins and the bound checker
`timescale 1ns/1ps
`include "pso_defs.svh"
module tb_pso_output_control;
   localparam logic [6:0] ADDR = {`PSO_ADDR_HI, 4'h5};
   logic sys_clk = 1'b0, reset = 1'b1, alert_event = 1'b0, enable_pin = 1'b0, input_overcurrent_warning_limit = 1'b0;
   logic [15:0] vin_sense_fix = 16'h0C00;
   logic scl_in, sda_host, sda_out, sda_oe, alert_out, alert_oe, output_enable, margin_fault_act;
   logic regulator_hot_flag, init_done, nak;
   logic [15:0] vout_target, rdata;
   logic [3:0] codes [6] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA};
   int mismatches = 0, checks_done = 0, cycles = 0;
   wire sda_in = sda_host & ~sda_oe;
   pso_output_control u_pso_output_control (.sys_clk, .reset, .scl_in, .sda_in, .sda_out, .sda_oe, .alert_event,
      .alert_out, .alert_oe, .address_risetime_strap_pin(4'h5), .strap_mode(1'b0), .strap_boot_vid(8'h00),
      .enable_pin, .input_overcurrent_warning_limit, .vin_sense_fix, .output_enable, .vout_target,
      .margin_fault_act, .regulator_hot_flag, .init_done);
   pso_host_model u_pso_host_model (.sys_clk, .sda_in, .scl_in, .sda_host);
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (++cycles == 90000) begin
      mismatches++;
      give_verdict();
   end
   // ***
   // shared tasks
   // ***
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d, input int p = 0);
      u_pso_host_model.xact(ADDR, c, n, d, 0, p, rdata, nak);
      tick(4);
   endtask
   task automatic rd(input string what, input logic [7:0] c, input int n, input logic [15:0] exp);
      u_pso_host_model.xact(ADDR, c, 0, 16'h0000, n, 0, rdata, nak);
      check(what, exp, rdata);
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      check(what, {15'h0000, exp}, {15'h0000, got});
   endtask
   task automatic do_reset();
      reset = 1'b1;
      tick(16);
      reset = 1'b0;
      tick(12);
   endtask
   task automatic give_verdict();
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ***
   // scenarios
   // ***
   task automatic t_defaults();
      rd("operation", `PSO_CMD_OPER, 1, 16'hFF00);
      rd("on_off_cfg", `PSO_CMD_ONOFF, 1, 16'hFF17);
      rd("vout_mode", `PSO_CMD_VMODE, 1, 16'hFF20);
      u_pso_host_model.xact(ADDR ^ 7'h01, `PSO_CMD_OPER, 0, 16'h0000, 1, 0, rdata, nak);
      check_bit("other_addr_nak", 1'b1, nak);
   endtask
   task automatic t_on_off();
      wr(`PSO_CMD_OPER, 1, 16'h00C0);
      rd("soft_off_ro", `PSO_CMD_OPER, 1, 16'hFF80);
      check_bit("on_ignored", 1'b0, output_enable);
      wr(`PSO_CMD_ONOFF, 1, 16'h0008);
      check_bit("on_bus_only", 1'b1, output_enable);
      wr(`PSO_CMD_ONOFF, 1, 16'h000C);
      check_bit("pin_low_off", 1'b0, output_enable);
      enable_pin = 1'b1;
      tick(8);
      check_bit("pin_high_on", 1'b1, output_enable);
      vin_sense_fix = 16'h0300;
      tick(8);
      check_bit("uv_off", 1'b0, output_enable);
      vin_sense_fix = 16'h0C00;
   endtask
   task automatic t_pec();
      wr(`PSO_CMD_ONOFF, 1, 16'h0008, 2);
      rd("bad_pec_kept", `PSO_CMD_ONOFF, 1, 16'hFF1F);
      wr(`PSO_CMD_ONOFF, 1, 16'h0008, 1);
      rd("good_pec_taken", `PSO_CMD_ONOFF, 1, 16'hFF1B);
   endtask
   task automatic t_margin();
      logic [15:0] exp;
      wr(`PSO_CMD_VCMD, 2, 16'h0050);
      wr(`PSO_CMD_MHI, 2, 16'h0060);
      wr(`PSO_CMD_MLO, 2, 16'h0040);
      for (int i = 0; i < 6; i++) begin
         wr(`PSO_CMD_OPER, 1, {8'h00, 2'b10, codes[i], 2'b00});
         exp = codes[i][3:2] == 2'b01 ? 16'h0040 : codes[i][3:2] == 2'b10 ? 16'h0060 : 16'h0050;
         check("vout_target", exp, vout_target);
         check_bit("fault_act", codes[i] == 4'h6 || codes[i] == 4'hA, margin_fault_act);
      end
   endtask
   task automatic t_hot_linear();
      wr(`PSO_CMD_OPER, 1, 16'h0081);
      input_overcurrent_warning_limit = 1'b1;
      tick(3);
      check_bit("hot_on", 1'b1, regulator_hot_flag);
      wr(`PSO_CMD_OPER, 1, 16'h0083);
      check_bit("hot_other", 1'b0, regulator_hot_flag);
      rd("vin_linear", `PSO_CMD_VIN, 2, 16'hF030);
      wr(`PSO_CMD_UVLO, 2, 16'hF810);
      rd("uvlo_renorm", `PSO_CMD_UVLO, 2, 16'hF020);
      vin_sense_fix = 16'h0700;
      tick(8);
      check_bit("uv_8v_off", 1'b0, output_enable);
   endtask
   task automatic t_alert();
      u_pso_host_model.xact(`PSO_ARA, 8'h00, -1, 16'h0000, 1, 0, rdata, nak);
      check_bit("ara_idle_nak", 1'b1, nak);
      alert_event = 1'b1;
      tick(1);
      alert_event = 1'b0;
      u_pso_host_model.xact(`PSO_ARA, 8'h00, -1, 16'h0000, 1, 0, rdata, nak);
      check("ara_addr", {8'hFF, ADDR, 1'b0}, rdata);
      check_bit("alert_cleared", 1'b0, alert_oe);
   endtask
   task automatic t_store();
      do_reset();
      rd("not_stored", `PSO_CMD_ONOFF, 1, 16'hFF17);
      wr(`PSO_CMD_ONOFF, 1, 16'h0008);
      wr(`PSO_CMD_STORE, 0, 16'h0000);
      tick(10);
      do_reset();
      rd("stored", `PSO_CMD_ONOFF, 1, 16'hFF1B);
   endtask
   initial begin
      do_reset();
      t_defaults();
      t_on_off();
      t_pec();
      t_margin();
      t_hot_linear();
      t_alert();
      t_store();
      give_verdict();
   end
endmodule // tb_pso_output_control
